// File: verilog/status_reporter_regs.svh
/*
 * Word offsets, field positions, codes and timing figures of the unit status
 * reporter. Assumes it is included by bare name from design files only.
 */
`ifndef STATUS_REPORTER_REGS_SVH
`define STATUS_REPORTER_REGS_SVH

// Word offsets inside the shared word memory control area.
`define OFFSET_W                7
`define UNIT_STATUS_OFFSET      7'h01
`define SYNTAX_ADDR_OFFSET      7'h02

// Field positions of the unit status word.
`define CODE_LSB                0
`define CODE_W                  8
`define RUN_DIGIT_LSB           8
`define TOP_DIGIT_LSB           12

// Digit values.
`define TOP_DIGIT_FATAL         4'h8
`define TOP_DIGIT_CLEAR         4'h0
`define RUN_DIGIT_RUNNING       4'h1
`define RUN_DIGIT_STOPPED       4'h0

// Error codes, already in BCD.
`define CODE_WATCHDOG           8'h01
`define CODE_SYNTAX             8'h02
`define CODE_ALLOCATION         8'h15

// Reset values.
`define UNIT_STATUS_RESET       16'h0000
`define SYNTAX_ADDR_RESET       16'h0000

// Timing.
`define CLK_PERIOD_NS           10
`define BLINK_HALF_MS           500

`endif

// File: verilog/status_reporter_pkg.sv
/*
 * Types shared by the unit status reporter files.
 * Assumes nothing of its surroundings.
 */
package status_reporter_pkg;

    typedef enum logic [1:0] {
        led_off,
        led_steady,
        led_blink
    } led_mode_t;

endpackage : status_reporter_pkg

// File: verilog/bcd_encoder.sv
/*
 * Combinational binary to packed BCD converter by shift and add-three.
 * Assumes the binary value fits in DIGITS decimal digits.
 */
module bcd_encoder #(
    parameter int BIN_W  = 5,
    parameter int DIGITS = 2
) (
    input  wire logic [BIN_W-1:0]    bin,
    output logic      [DIGITS*4-1:0] bcd
);

    logic [DIGITS*4-1:0] acc;

    always_comb begin
        acc = '0;
        for (int i = BIN_W - 1; i >= 0; i--) begin
            for (int d = 0; d < DIGITS; d++) begin
                if (acc[d*4 +: 4] > 4'h4) begin
                    acc[d*4 +: 4] = acc[d*4 +: 4] + 4'h3;
                end
            end
            acc = {acc[DIGITS*4-2:0], bin[i]};
        end
        bcd = acc;
    end

endmodule : bcd_encoder

// File: verilog/unit_status_reporter.sv
/*
 * Status and error reporting of a serial communications unit that polls field
 * components for a controller CPU. It keeps the unit status word and the
 * syntax fault address word, writes them into the CPU's shared word memory
 * over a one-cycle write strobe, gates component polling and the CPU link, and
 * drives the fault indicator.
 * Assumes fault inputs and the polled unit strobe come from logic on ref_clk,
 * and that the shared memory takes every write strobe without stalling.
 */
// What this block does
// (RULE1) While a fatal error is flagged, the status low byte holds code 01, 02 or 15.
// (RULE2) Watchdog fault: write the status word first, then halt all traffic, indicator on.
// (RULE3) Syntax fault: write the fault address, then stop polling, indicator blinks.
// (RULE4) Missing memory address: allocation fault, stop polling, indicator steadily on.
// (RULE5) On any error operation stops and the run digit reads zero.
// (RULE6) A fatal error writes 8 into the top digit, setting bit 15.
// (RULE7) Without fatal error the low byte shows the last polled unit in BCD.
// (RULE8) Without fatal error the run digit is one running, zero stopped.
// (RULE9) Without fatal error the top digit stays zero.
// (RULE10) CPU side faults cannot be reported: halt all traffic, indicator steadily on.
// (RULE11) The syntax fault address is written to its word in BCD.
// (RULE12) Only the first syntax fault address is kept.
// (RULE13) A latched fatal error blocks polling even with the run digit set.
// (RULE14) The indicator is off, steady or blinking after the worst latched error.
`include "status_reporter_regs.svh"

module unit_status_reporter #(
    parameter int BLINK_HALF_CYCLES = `BLINK_HALF_MS * 1000000 / `CLK_PERIOD_NS
) (
    input  wire logic                  ref_clk,
    input  wire logic                  resetn,
    input  wire logic                  run_cmd,
    input  wire logic                  unit_done,
    input  wire logic [4:0]            unit_num,
    input  wire logic                  watchdog_fault,
    input  wire logic                  syntax_fault,
    input  wire logic [13:0]           syntax_fault_at,
    input  wire logic                  alloc_fault,
    input  wire logic                  shared_write_blocked,
    input  wire logic                  cpu_comm_fail,
    input  wire logic                  program_protected,
    output logic      [15:0]           unit_status_word,
    output logic      [15:0]           syntax_fault_address,
    output logic                       mem_wr_en,
    output logic      [`OFFSET_W-1:0]  mem_wr_offset,
    output logic      [15:0]           mem_wr_data,
    output logic                       poll_enable,
    output logic                       cpu_link_enable,
    output logic                       fault_led
);

    localparam int BLINK_W = $clog2(BLINK_HALF_CYCLES + 1);

    // Sticky error state; only reset clears it.
    logic                   wdt_reg;
    logic                   syn_reg;
    logic                   alloc_reg;
    logic                   cpu_fault_reg;
    logic [`CODE_W-1:0]     code_reg;
    logic                   reported_reg;
    logic                   wdt_told_reg;
    logic                   syn_pend_reg;
    logic [4:0]             last_unit_reg;
    logic [15:0]            status_reg;
    logic [15:0]            shown_reg;
    logic [15:0]            syn_addr_reg;
    logic                   wr_en_reg;
    logic [`OFFSET_W-1:0]   wr_off_reg;
    logic [15:0]            wr_data_reg;
    logic                   poll_reg;
    logic                   link_reg;
    logic                   led_reg;
    logic [BLINK_W-1:0]     blink_cnt_reg;
    logic                   blink_reg;

    logic                   wdt_next;
    logic                   syn_next;
    logic                   alloc_next;
    logic                   cpu_fault_next;
    logic                   fatal_any;
    logic                   error_any;
    logic                   first_error;
    logic [`CODE_W-1:0]     code_next;
    logic [7:0]             unit_bcd;
    logic [15:0]            addr_bcd;
    logic [15:0]            status_next;
    logic                   can_write;
    logic                   put_syntax;
    logic                   put_status;
    logic                   reported_next;
    logic                   wdt_told_next;
    logic                   poll_next;
    logic                   link_next;
    logic                   blink_wrap;
    status_reporter_pkg::led_mode_t led_mode;

    bcd_encoder #(
        .BIN_W  (5),
        .DIGITS (2)
    ) u_unit_bcd (
        .bin (last_unit_reg),
        .bcd (unit_bcd)
    );

    bcd_encoder #(
        .BIN_W  (14),
        .DIGITS (4)
    ) u_addr_bcd (
        .bin (syntax_fault_at),
        .bcd (addr_bcd)
    );

    assign wdt_next       = wdt_reg | watchdog_fault;
    assign syn_next       = syn_reg | syntax_fault;
    assign alloc_next     = alloc_reg | alloc_fault;
    assign cpu_fault_next = cpu_fault_reg | shared_write_blocked | cpu_comm_fail | program_protected; // RULE10
    assign fatal_any      = wdt_reg | alloc_reg;
    assign error_any      = fatal_any | syn_reg;
    assign first_error    = ~error_any & syntax_fault;

    // A fatal code replaces a syntax code; the first fatal code is then kept.
    assign code_next = fatal_any       ? code_reg :
                       watchdog_fault  ? `CODE_WATCHDOG :
                       alloc_fault     ? `CODE_ALLOCATION :
                       first_error     ? `CODE_SYNTAX :
                                         code_reg; // RULE1

    // Error layout: top digit 8, run digit 0, code in the low byte.
    assign status_next = error_any ?
                         {`TOP_DIGIT_FATAL, `RUN_DIGIT_STOPPED, code_reg} : // RULE1 RULE5 RULE6
                         {`TOP_DIGIT_CLEAR,
                          (poll_reg ? `RUN_DIGIT_RUNNING : `RUN_DIGIT_STOPPED),
                          unit_bcd}; // RULE7 RULE8 RULE9

    // Nothing is written once the CPU side is broken or a watchdog halt holds;
    // the unregistered fault term also drops a strobe in the fault cycle itself.
    assign can_write  = ~cpu_fault_next & ~wdt_told_reg; // RULE2 RULE10
    // The syntax address goes out before the status word that announces it.
    assign put_syntax = can_write & syn_pend_reg; // RULE3 RULE11
    assign put_status = can_write & ~syn_pend_reg & (status_reg != shown_reg); // RULE2

    // Set once a status word carrying an error has been written out.
    assign reported_next = reported_reg | (put_status & status_reg[15]);

    // The watchdog halt waits until the word carrying its code is out, even when
    // an earlier syntax report has already been written.
    assign wdt_told_next = wdt_told_reg | (wdt_reg & ~syn_pend_reg & status_reg[15]
                           & (put_status | (status_reg == shown_reg))
                           & (status_reg[`CODE_W-1:0] == code_next)); // RULE2

    // Polling stops at once for allocation and CPU faults, and only after the
    // report for watchdog and syntax faults.
    assign poll_next = run_cmd & ~alloc_next & ~cpu_fault_next
                       & ~wdt_told_reg & ~(syn_reg & reported_reg); // RULE3 RULE4 RULE5 RULE13
    assign link_next = ~cpu_fault_next & ~wdt_told_reg; // RULE2 RULE10

    assign led_mode = (cpu_fault_reg | alloc_reg | wdt_told_reg)          ? status_reporter_pkg::led_steady :
                      (syn_reg & reported_reg)                               ? status_reporter_pkg::led_blink :
                                                                               status_reporter_pkg::led_off; // RULE14

    assign blink_wrap = (blink_cnt_reg == BLINK_W'(BLINK_HALF_CYCLES - 1));

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wdt_reg       <= 1'b0;
            syn_reg       <= 1'b0;
            alloc_reg     <= 1'b0;
            cpu_fault_reg <= 1'b0;
            code_reg      <= 8'h00;
            reported_reg  <= 1'b0;
            wdt_told_reg  <= 1'b0;
        end else begin
            wdt_reg       <= wdt_next;
            syn_reg       <= syn_next;
            alloc_reg     <= alloc_next; // RULE4
            cpu_fault_reg <= cpu_fault_next;
            code_reg      <= code_next;
            reported_reg  <= reported_next;
            wdt_told_reg  <= wdt_told_next;
        end
    end

    // The first syntax fault wins; later ones leave the address alone.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            syn_addr_reg <= `SYNTAX_ADDR_RESET;
            syn_pend_reg <= 1'b0;
        end else if (syntax_fault && !syn_reg) begin
            syn_addr_reg <= addr_bcd; // RULE11 RULE12
            syn_pend_reg <= 1'b1;
        end else if (put_syntax) begin
            syn_pend_reg <= 1'b0;
        end
    end

    // The unit number freezes once any error is latched.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            last_unit_reg <= 5'h00;
        end else if (unit_done && poll_reg && !error_any) begin
            last_unit_reg <= unit_num; // RULE7
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            status_reg <= `UNIT_STATUS_RESET;
            shown_reg  <= `UNIT_STATUS_RESET;
        end else begin
            status_reg <= status_next;
            if (put_status) begin
                shown_reg <= status_reg;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wr_en_reg   <= 1'b0;
            wr_off_reg  <= `UNIT_STATUS_OFFSET;
            wr_data_reg <= `UNIT_STATUS_RESET;
        end else begin
            wr_en_reg <= put_syntax | put_status;
            if (put_syntax) begin
                wr_off_reg  <= `SYNTAX_ADDR_OFFSET;
                wr_data_reg <= syn_addr_reg; // RULE3
            end else if (put_status) begin
                wr_off_reg  <= `UNIT_STATUS_OFFSET;
                wr_data_reg <= status_reg; // RULE2
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            poll_reg <= 1'b0;
            link_reg <= 1'b0;
        end else begin
            poll_reg <= poll_next; // RULE13
            link_reg <= link_next;
        end
    end

    // The blink timebase free-runs from reset, so the first half period after blinking starts can be short.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            blink_cnt_reg <= '0;
            blink_reg     <= 1'b0;
        end else if (blink_wrap) begin
            blink_cnt_reg <= '0;
            blink_reg     <= ~blink_reg;
        end else begin
            blink_cnt_reg <= blink_cnt_reg + BLINK_W'(1);
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            led_reg <= 1'b0;
        end else begin
            unique case (led_mode)
                status_reporter_pkg::led_steady: led_reg <= 1'b1; // RULE2 RULE4 RULE10
                status_reporter_pkg::led_blink:  led_reg <= blink_reg; // RULE3
                status_reporter_pkg::led_off:    led_reg <= 1'b0;
                default:                         led_reg <= 1'b1;
            endcase
        end
    end

    assign unit_status_word     = status_reg;
    assign syntax_fault_address = syn_addr_reg;
    assign mem_wr_en            = wr_en_reg;
    assign mem_wr_offset        = wr_off_reg;
    assign mem_wr_data          = wr_data_reg;
    assign poll_enable          = poll_reg;
    assign cpu_link_enable      = link_reg;
    assign fault_led            = led_reg;

endmodule : unit_status_reporter

// File: tb/status_reporter_props.sv
/*
 * Port assertions for the unit status reporter.
 * Assumes one clock, ref_clk, and reset resetn, active low.
 */
module status_reporter_props (
    input wire logic        ref_clk,
    input wire logic        resetn,
    input wire logic        watchdog_fault,
    input wire logic        alloc_fault,
    input wire logic        shared_write_blocked,
    input wire logic        cpu_comm_fail,
    input wire logic        program_protected,
    input wire logic [15:0] unit_status_word,
    input wire logic [15:0] syntax_fault_address,
    input wire logic        mem_wr_en,
    input wire logic [6:0]  mem_wr_offset,
    input wire logic [15:0] mem_wr_data,
    input wire logic        poll_enable,
    input wire logic        cpu_link_enable,
    input wire logic        fault_led
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    chk_fatal_layout: assert property (unit_status_word[15] |-> unit_status_word[14:8] == 7'h00)
        else $error("error layout of status word wrong");
    chk_fatal_code: assert property (unit_status_word[15] |-> unit_status_word[7:0] inside {8'h01, 8'h02, 8'h15})
        else $error("error code not a known code");
    chk_normal_layout: assert property (!unit_status_word[15] |-> unit_status_word[15:9] == 7'h00
        && unit_status_word[7:4] <= 4'h3 && unit_status_word[3:0] <= 4'h9)
        else $error("normal layout of status word wrong");
    chk_write_before_halt: assert property (mem_wr_en |-> cpu_link_enable)
        else $error("write strobe while link halted");
    chk_syntax_write: assert property (mem_wr_en && mem_wr_offset == 7'h02 |-> mem_wr_data == syntax_fault_address)
        else $error("syntax address write carries wrong data");
    chk_first_kept: assert property (syntax_fault_address != 16'h0000 |=> $stable(syntax_fault_address))
        else $error("syntax address overwritten");
    chk_error_stops: assert property ($rose(unit_status_word[15]) |-> ##[0:3] !poll_enable ##1 !poll_enable[*4])
        else $error("polling goes on after error");
    chk_watchdog_halt: assert property (watchdog_fault |-> ##[1:5] (!cpu_link_enable && !poll_enable && fault_led))
        else $error("watchdog fault did not halt");
    chk_alloc_halt: assert property (alloc_fault |-> ##[1:3] (!poll_enable && fault_led))
        else $error("allocation fault did not halt");
    chk_cpu_side_halt: assert property ((shared_write_blocked || cpu_comm_fail || program_protected)
        |-> ##[1:3] (!cpu_link_enable && !poll_enable && fault_led))
        else $error("cpu side fault did not halt");

    cover property (mem_wr_en && mem_wr_offset == 7'h02);
    cover property (mem_wr_en && !unit_status_word[15]);
    cover property ($rose(fault_led));
endmodule : status_reporter_props

bind unit_status_reporter status_reporter_props i_props (.ref_clk, .resetn, .watchdog_fault, .alloc_fault,
    .shared_write_blocked, .cpu_comm_fail, .program_protected, .unit_status_word, .syntax_fault_address,
    .mem_wr_en, .mem_wr_offset, .mem_wr_data, .poll_enable, .cpu_link_enable, .fault_led);

// File: tb/shared_mem_model.sv
/*
 * Controller side shared word memory: keeps the two reported words.
 * Assumes it takes every write strobe at once, as the reporter expects.
 */
module shared_mem_model (
    input  wire logic        ref_clk,
    input  wire logic        mem_wr_en,
    input  wire logic [6:0]  mem_wr_offset,
    input  wire logic [15:0] mem_wr_data,
    output logic      [15:0] status_copy,
    output logic      [15:0] addr_copy,
    output int               wr_count
);
    timeunit 1ns;
    timeprecision 1ps;

    // The count starts at zero so the bench can difference it at any time.
    int writes = 0;

    assign wr_count = writes;

    always @(posedge ref_clk) begin
        if (mem_wr_en) begin
            writes <= writes + 1;
            if (mem_wr_offset == 7'h01) begin
                status_copy <= mem_wr_data;
            end
            if (mem_wr_offset == 7'h02) begin
                addr_copy <= mem_wr_data;
            end
        end
    end
endmodule : shared_mem_model

// File: tb/comm_unit_status_reporter_tb.sv
/*
 * Self-checking bench of the unit status reporter with a shared memory model.
 * Assumes the error state clears only by reset, so each error test resets.
 */
module comm_unit_status_reporter_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        ref_clk, resetn, run_cmd, unit_done, watchdog_fault, syntax_fault, led_prev;
    logic        alloc_fault, shared_write_blocked, cpu_comm_fail, program_protected;
    logic        mem_wr_en, poll_enable, cpu_link_enable, fault_led;
    logic [4:0]  unit_num;
    logic [13:0] syntax_fault_at;
    logic [6:0]  mem_wr_offset;
    logic [15:0] unit_status_word, syntax_fault_address, mem_wr_data, status_copy, addr_copy;
    int          fails = 0, n_compared = 0, cycles = 0, wr_count, k, seen;

    unit_status_reporter #(.BLINK_HALF_CYCLES(4)) i_dut (.ref_clk, .resetn, .run_cmd, .unit_done, .unit_num,
        .watchdog_fault, .syntax_fault, .syntax_fault_at, .alloc_fault, .shared_write_blocked, .cpu_comm_fail,
        .program_protected, .unit_status_word, .syntax_fault_address, .mem_wr_en, .mem_wr_offset, .mem_wr_data,
        .poll_enable, .cpu_link_enable, .fault_led);
    shared_mem_model i_cpu (.ref_clk, .mem_wr_en, .mem_wr_offset, .mem_wr_data, .status_copy, .addr_copy,
        .wr_count);

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run

    // The whole run needs about 220 cycles.
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fails++;
            complete_run();
        end
    end

    task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step

    task automatic restart(input logic run);
        @(posedge ref_clk);
        resetn <= 1'b0;
        run_cmd <= run;
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        step(6);
    endtask : restart

    task automatic poll_unit(input logic [4:0] n);
        @(posedge ref_clk);
        unit_done <= 1'b1;
        unit_num <= n;
        @(posedge ref_clk);
        unit_done <= 1'b0;
        step(4);
    endtask : poll_unit

    task automatic hit(input int f, input logic [13:0] at);
        @(posedge ref_clk);
        syntax_fault_at <= at;
        case (f)
            0: watchdog_fault <= 1'b1;
            1: syntax_fault <= 1'b1;
            2: alloc_fault <= 1'b1;
            3: shared_write_blocked <= 1'b1;
            4: cpu_comm_fail <= 1'b1;
            default: program_protected <= 1'b1;
        endcase
        @(posedge ref_clk);
        {watchdog_fault, syntax_fault, alloc_fault, shared_write_blocked, cpu_comm_fail, program_protected} <= 6'h00;
        step(6);
    endtask : hit

    initial begin
        {resetn, run_cmd, unit_done, unit_num, syntax_fault_at} = '0;
        {watchdog_fault, syntax_fault, alloc_fault, shared_write_blocked, cpu_comm_fail, program_protected} = '0;
        restart(1'b1);
        poll_unit(5'd12);
        check("status", unit_status_word, 16'h0112);
        check("cpu status", status_copy, 16'h0112);
        check("led", 16'(fault_led), 16'h0000);
        check("link", 16'(cpu_link_enable), 16'h0001);
        poll_unit(5'd31);
        check("status", unit_status_word, 16'h0131);
        @(posedge ref_clk);
        run_cmd <= 1'b0;
        step(5);
        check("status", unit_status_word, 16'h0031);
        $display("test normal done");

        restart(1'b1);
        hit(1, 14'd9999);
        check("fault address", syntax_fault_address, 16'h9999);
        check("cpu address", addr_copy, 16'h9999);
        check("status", unit_status_word, 16'h8002);
        check("cpu status", status_copy, 16'h8002);
        check("poll", 16'(poll_enable), 16'h0000);
        hit(1, 14'd1234);
        check("fault address", syntax_fault_address, 16'h9999);
        poll_unit(5'd7);
        check("status", unit_status_word, 16'h8002);
        seen = 0;
        led_prev = fault_led;
        repeat (20) begin
            step(1);
            seen += int'(fault_led !== led_prev);
            led_prev = fault_led;
        end
        check("led blink", 16'(seen >= 4), 16'h0001);
        $display("test syntax done");

        restart(1'b1);
        hit(0, 14'd0);
        check("cpu status", status_copy, 16'h8001);
        check("link", 16'(cpu_link_enable), 16'h0000);
        check("led", 16'(fault_led), 16'h0001);
        restart(1'b1);
        hit(2, 14'd0);
        check("status", unit_status_word, 16'h8015);
        check("poll and led", 16'({poll_enable, fault_led}), 16'h0001);
        $display("test fatal done");

        for (k = 3; k < 6; k++) begin
            restart(1'b1);
            seen = wr_count;
            hit(k, 14'd0);
            check("link poll led", 16'({cpu_link_enable, poll_enable, fault_led}), 16'h0001);
            check("writes", 16'(wr_count - seen), 16'h0000);
            check("status", unit_status_word, 16'h0000);
        end
        $display("test cpu side done");
        complete_run();
    end
endmodule : comm_unit_status_reporter_tb
